// ==== hw/ivt_pkg.sv ====
// constants for the input voltage threshold register bank
//==========================================================
// Overview of operation
// - unused upper bits ignore writes, read zero
// - over-voltage fault limit is bits 6:0
// - over-voltage warning limit is bits 6:0
// - under-voltage warning limit is bits 6:0
// - resolution 500, 250 or 125 mV per step
// - power-good rise threshold, 10 bits, 62.5 mV
// - separate falling threshold gives power-good hysteresis
package ivt_pkg;
   // command codes of the threshold registers
   localparam logic [7:0] IVT_CMD_OV_FAULT = 8'h55;
   localparam logic [7:0] IVT_CMD_OV_WARN = 8'h57;
   localparam logic [7:0] IVT_CMD_UV_WARN = 8'h58;
   localparam logic [7:0] IVT_CMD_GOOD_RISE = 8'h5E;
   localparam logic [7:0] IVT_CMD_GOOD_FALL = 8'h5F;
   // field widths: 7-bit voltage limits, 10-bit power-good levels
   localparam int IVT_LIM_W = 7;
   localparam int IVT_PG_W = 10;
   // samples and thresholds are counted in 62.5 mV units
   localparam int IVT_SMP_W = 11;
   // resolution shifts: 125 mV = 2 units, 250 mV = 4, 500 mV = 8
   localparam logic [1:0] IVT_SHIFT_125MV = 2'h1;
   localparam logic [1:0] IVT_SHIFT_250MV = 2'h2;
   localparam logic [1:0] IVT_SHIFT_500MV = 2'h3;
   // reset values, plain defaults
   localparam logic [6:0] IVT_RST_OV_FAULT = 7'h7F;
   localparam logic [6:0] IVT_RST_OV_WARN = 7'h7F;
   localparam logic [6:0] IVT_RST_UV_WARN = 7'h00;
   localparam logic [9:0] IVT_RST_GOOD_RISE = 10'h000;
   localparam logic [9:0] IVT_RST_GOOD_FALL = 10'h000;
endpackage : ivt_pkg

// ==== hw/ivt_regs.sv ====
// input voltage threshold registers with limit comparators and power-good
`timescale 1ns/1ps
module ivt_regs
   import ivt_pkg::*;
(
   input wire logic core_clk, // 200 MHz
   input wire logic rst_b, // asynchronous, active low
   input wire logic cmd_valid, // pulse: new command code, restarts byte pairing
   input wire logic [7:0] cmd_code, // command code of the transaction
   input wire logic wr_byte_valid, // pulse: one written data byte
   input wire logic [7:0] wr_byte, // written data byte
   input wire logic rd_req, // pulse: word read of the current command
   input wire logic fine_res_sel, // selection bit from the config register at C4h
   input wire logic mid_res_sel, // selection bit from the config register at E7h
   input wire logic sample_valid, // pulse: new conversion results
   input wire logic [10:0] vin_sample, // input voltage, 62.5 mV units
   input wire logic [10:0] vout_sample, // monitored output voltage, 62.5 mV units
   output logic [15:0] rd_data, // read word, low byte sent first by the engine
   output logic rd_valid, // pulse: rd_data valid
   output logic input_overvoltage_fault, // level
   output logic input_overvoltage_warning, // level
   output logic input_low_voltage_warning, // level
   output logic output_good_indication // level
);
   //==========================================================
   // register state
   logic [7:0] cmd_reg, cmd_next; // latched command code
   logic [7:0] lo_reg, lo_next; // low byte waiting for its partner
   logic lo_pend_reg, lo_pend_next; // low byte already received
   logic [6:0] ovf_reg, ovf_next; // over-voltage fault limit field
   logic [6:0] ovw_reg, ovw_next; // over-voltage warning limit field
   logic [6:0] uvw_reg, uvw_next; // under-voltage warning limit field
   logic [9:0] rise_reg, rise_next; // power-good rising level
   logic [9:0] fall_reg, fall_next; // power-good falling level
   logic [15:0] rd_data_reg, rd_data_next;
   logic rd_valid_reg, rd_valid_next;
   logic [15:0] word_in; // assembled write word

   // byte pairing and register writes
   always_comb begin
      cmd_next = cmd_reg;
      lo_next = lo_reg;
      lo_pend_next = lo_pend_reg;
      ovf_next = ovf_reg;
      ovw_next = ovw_reg;
      uvw_next = uvw_reg;
      rise_next = rise_reg;
      fall_next = fall_reg;
      word_in = {wr_byte, lo_reg};
      if (cmd_valid) begin
         // a new command drops any half word left over
         cmd_next = cmd_code;
         lo_pend_next = 1'b0;
      end else if (wr_byte_valid && !lo_pend_reg) begin
         lo_next = wr_byte;
         lo_pend_next = 1'b1;
      end else if (wr_byte_valid) begin
         // high byte completes the word; upper bits are simply not stored
         lo_pend_next = 1'b0;
         case (cmd_reg)
            IVT_CMD_OV_FAULT: ovf_next = word_in[6:0];
            IVT_CMD_OV_WARN: ovw_next = word_in[6:0];
            IVT_CMD_UV_WARN: uvw_next = word_in[6:0];
            IVT_CMD_GOOD_RISE: rise_next = word_in[9:0];
            IVT_CMD_GOOD_FALL: fall_next = word_in[9:0];
            default: ; // unknown codes are ignored
         endcase
      end
   end

   // read mux: unused bits return zero, unknown codes return zero
   always_comb begin
      rd_valid_next = rd_req;
      rd_data_next = rd_data_reg;
      if (rd_req) begin
         case (cmd_reg)
            IVT_CMD_OV_FAULT: rd_data_next = {9'h000, ovf_reg};
            IVT_CMD_OV_WARN: rd_data_next = {9'h000, ovw_reg};
            IVT_CMD_UV_WARN: rd_data_next = {9'h000, uvw_reg};
            IVT_CMD_GOOD_RISE: rd_data_next = {6'h00, rise_reg};
            IVT_CMD_GOOD_FALL: rd_data_next = {6'h00, fall_reg};
            default: rd_data_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_reg <= 8'h00;
         lo_reg <= 8'h00;
         lo_pend_reg <= 1'b0;
         ovf_reg <= IVT_RST_OV_FAULT;
         ovw_reg <= IVT_RST_OV_WARN;
         uvw_reg <= IVT_RST_UV_WARN;
         rise_reg <= IVT_RST_GOOD_RISE;
         fall_reg <= IVT_RST_GOOD_FALL;
         rd_data_reg <= 16'h0000;
         rd_valid_reg <= 1'b0;
      end else begin
         cmd_reg <= cmd_next;
         lo_reg <= lo_next;
         lo_pend_reg <= lo_pend_next;
         ovf_reg <= ovf_next;
         ovw_reg <= ovw_next;
         uvw_reg <= uvw_next;
         rise_reg <= rise_next;
         fall_reg <= fall_next;
         rd_data_reg <= rd_data_next;
         rd_valid_reg <= rd_valid_next;
      end
   end

   //==========================================================
   // threshold scaling and comparators
   logic [1:0] shift; // resolution as a shift in 62.5 mV units
   logic [10:0] ovf_thr, ovw_thr, uvw_thr; // scaled thresholds
   logic ovf_flag_reg, ovf_flag_next; // over-voltage fault flag
   logic ovw_flag_reg, ovw_flag_next;
   logic uvw_flag_reg, uvw_flag_next;
   logic pg_reg, pg_next;

   // resolution select; the fine bit overrides the other
   always_comb begin
      if (fine_res_sel) begin
         shift = IVT_SHIFT_125MV;
      end else if (mid_res_sel) begin
         shift = IVT_SHIFT_250MV;
      end else begin
         shift = IVT_SHIFT_500MV;
      end
      ovf_thr = {4'h0, ovf_reg} << shift;
      ovw_thr = {4'h0, ovw_reg} << shift;
      uvw_thr = {4'h0, uvw_reg} << shift;
   end

   // flags only move on a fresh sample; limit edits take effect next sample
   always_comb begin
      ovf_flag_next = ovf_flag_reg;
      ovw_flag_next = ovw_flag_reg;
      uvw_flag_next = uvw_flag_reg;
      pg_next = pg_reg;
      if (sample_valid) begin
         ovf_flag_next = vin_sample > ovf_thr;
         ovw_flag_next = vin_sample > ovw_thr;
         uvw_flag_next = vin_sample < uvw_thr;
         // between the two levels the indication keeps its state
         if (!pg_reg && vout_sample >= {1'b0, rise_reg}) begin
            pg_next = 1'b1;
         end else if (pg_reg && vout_sample <= {1'b0, fall_reg}) begin
            pg_next = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ovf_flag_reg <= 1'b0;
         ovw_flag_reg <= 1'b0;
         uvw_flag_reg <= 1'b0;
         pg_reg <= 1'b0;
      end else begin
         ovf_flag_reg <= ovf_flag_next;
         ovw_flag_reg <= ovw_flag_next;
         uvw_flag_reg <= uvw_flag_next;
         pg_reg <= pg_next;
      end
   end

   assign rd_data = rd_data_reg;
   assign rd_valid = rd_valid_reg;
   assign input_overvoltage_fault = ovf_flag_reg;
   assign input_overvoltage_warning = ovw_flag_reg;
   assign input_low_voltage_warning = uvw_flag_reg;
   assign output_good_indication = pg_reg;

   //==========================================================
   // checks
   // high byte that completes a word
   sequence s_word_write;
      !cmd_valid && wr_byte_valid && lo_pend_reg;
   endsequence
   // first byte after a command, parked until its partner comes
   sequence s_low_byte;
      !cmd_valid && wr_byte_valid && !lo_pend_reg;
   endsequence

   chk_fault_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
      rd_req && cmd_reg == IVT_CMD_OV_FAULT |=> rd_valid && rd_data[15:7] == 9'h000)
      else $error("fault limit read shows nonzero upper bits");
   chk_rise_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
      rd_req && cmd_reg == IVT_CMD_GOOD_RISE |=> rd_data == {6'h00, $past(rise_reg)})
      else $error("rise level read is wrong");
   chk_fault_write: assert property (@(posedge core_clk) disable iff (!rst_b)
      s_word_write ##0 (cmd_reg == IVT_CMD_OV_FAULT) |=> ovf_reg == 7'($past(lo_reg)))
      else $error("fault limit not stored");
   // expected threshold is rebuilt from the select bits, not from the scaler
   chk_ov_fault_cmp: assert property (@(posedge core_clk) disable iff (!rst_b)
      sample_valid |=> input_overvoltage_fault == ($past(vin_sample) >
         ($past(fine_res_sel) ? {3'h0, $past(ovf_reg), 1'b0} :
         $past(mid_res_sel) ? {2'h0, $past(ovf_reg), 2'h0} : {1'b0, $past(ovf_reg), 3'h0})))
      else $error("fault flag disagrees with threshold");
   chk_ov_warn_cmp: assert property (@(posedge core_clk) disable iff (!rst_b)
      sample_valid && fine_res_sel |=> input_overvoltage_warning ==
         ($past(vin_sample) > {2'h0, $past(ovw_reg), 2'h0} >> 1))
      else $error("warning flag wrong at fine resolution");
   chk_uv_warn_cmp: assert property (@(posedge core_clk) disable iff (!rst_b)
      sample_valid |=> input_low_voltage_warning == ($past(vin_sample) <
         ($past(fine_res_sel) ? {3'h0, $past(uvw_reg), 1'b0} :
         $past(mid_res_sel) ? {2'h0, $past(uvw_reg), 2'h0} : {1'b0, $past(uvw_reg), 3'h0})))
      else $error("low voltage warning disagrees with threshold");
   chk_res_coarse: assert property (@(posedge core_clk) disable iff (!rst_b)
      !fine_res_sel && !mid_res_sel |-> ovf_thr == {1'b0, ovf_reg, 3'h0})
      else $error("coarse resolution wrong");
   chk_pg_rise: assert property (@(posedge core_clk) disable iff (!rst_b)
      sample_valid && !pg_reg && vout_sample >= {1'b0, rise_reg} |=> output_good_indication)
      else $error("power good did not rise");
   chk_pg_fall: assert property (@(posedge core_clk) disable iff (!rst_b)
      sample_valid && pg_reg && vout_sample <= {1'b0, fall_reg} |=> !output_good_indication)
      else $error("power good did not fall");
   chk_pg_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
      !sample_valid |=> $stable(output_good_indication))
      else $error("power good moved without a sample");
   // a new command must drop a half word, or the next byte would commit garbage
   chk_cmd_drops_half: assert property (@(posedge core_clk) disable iff (!rst_b)
      cmd_valid |=> !lo_pend_reg)
      else $error("half word survived a new command");
   // the low byte is parked, not committed
   chk_low_byte_held: assert property (@(posedge core_clk) disable iff (!rst_b)
      s_low_byte |=> lo_pend_reg && lo_reg == $past(wr_byte))
      else $error("low byte not parked");
   // every read is answered exactly one cycle later
   chk_read_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
      rd_req |=> rd_valid)
      else $error("read not answered");
   // and the answer is a single-cycle pulse
   chk_read_single: assert property (@(posedge core_clk) disable iff (!rst_b)
      !rd_req |=> !rd_valid)
      else $error("read answer without a request");
endmodule : ivt_regs

// ==== verif/ivt_host_model.sv ====
// host-side model that issues word reads and writes to the threshold registers
`timescale 1ns/1ps
module ivt_host_model (
   input wire logic core_clk,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic wr_byte_valid,
   output logic [7:0] wr_byte,
   output logic rd_req,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid
);
   //==========================================================
   // idle levels at time zero
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      wr_byte_valid = 1'b0;
      wr_byte = 8'h00;
      rd_req = 1'b0;
   end
   // command phase shared by reads and writes
   task automatic send_cmd(input logic [7:0] code);
      @(posedge core_clk);
      cmd_valid <= 1'b1;
      cmd_code <= code;
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      cmd_code <= ~code; // released lines must not keep a stale code
   endtask : send_cmd
   // word write, low byte first, committed by the second byte
   task automatic write_word(input logic [7:0] code, input logic [15:0] data);
      send_cmd(code);
      wr_byte_valid <= 1'b1;
      wr_byte <= data[7:0];
      @(posedge core_clk);
      wr_byte <= data[15:8];
      @(posedge core_clk);
      wr_byte_valid <= 1'b0;
      wr_byte <= ~data[15:8];
      @(posedge core_clk);
   endtask : write_word
   // lone low byte that is never completed; the next command must drop it
   task automatic write_lone(input logic [7:0] code, input logic [7:0] data);
      send_cmd(code);
      wr_byte_valid <= 1'b1;
      wr_byte <= data;
      @(posedge core_clk);
      wr_byte_valid <= 1'b0;
      wr_byte <= ~data;
      @(posedge core_clk);
   endtask : write_lone
   // word read; the answer is taken once the answering edge has settled
   task automatic read_word(input logic [7:0] code, output logic [15:0] data,
         output logic ok);
      send_cmd(code);
      rd_req <= 1'b1;
      @(posedge core_clk);
      rd_req <= 1'b0;
      #1;
      ok = rd_valid;
      data = rd_data;
   endtask : read_word
endmodule : ivt_host_model

// ==== verif/test_input_voltage_threshold_regs.sv ====
// self-checking bench for the input voltage threshold registers
`timescale 1ns/1ps
module test_input_voltage_threshold_regs;
   import ivt_pkg::*;
   //==========================================================
   // signals
   typedef struct {logic [7:0] code; logic [15:0] wdat; logic [15:0] rdat;} ivt_row_t;
   ivt_row_t rows [6] = '{'{IVT_CMD_OV_FAULT, 16'hFFFF, 16'h007F},
      '{IVT_CMD_OV_WARN, 16'h1234, 16'h0034}, '{IVT_CMD_UV_WARN, 16'h0080, 16'h0000},
      '{IVT_CMD_GOOD_RISE, 16'hFFFF, 16'h03FF}, '{IVT_CMD_GOOD_FALL, 16'h0C05, 16'h0005},
      '{8'h60, 16'hFFFF, 16'h0000}}; // last row: unknown code reads zero
   logic [10:0] pg_v [5] = '{11'h013, 11'h014, 11'h00B, 11'h00A, 11'h00F};
   logic [4:0] pg_e = 5'h06; // hysteresis: holds high at 11, low again at 10, stays low at 15
   logic core_clk, rst_b, cmd_valid, wr_byte_valid, rd_req, rd_valid, ok;
   logic fine_res_sel, mid_res_sel, sample_valid, ov_f, ov_w, uv_w, pg_ok;
   logic [7:0] cmd_code, wr_byte;
   logic [10:0] vin_sample, vout_sample, thr;
   logic [15:0] rd_data, rd;
   int failures = 0;
   int checked = 0;
   ivt_regs dut (.core_clk(core_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte),
      .rd_req(rd_req), .fine_res_sel(fine_res_sel), .mid_res_sel(mid_res_sel),
      .sample_valid(sample_valid), .vin_sample(vin_sample), .vout_sample(vout_sample),
      .rd_data(rd_data), .rd_valid(rd_valid), .input_overvoltage_fault(ov_f),
      .input_overvoltage_warning(ov_w), .input_low_voltage_warning(uv_w),
      .output_good_indication(pg_ok));
   ivt_host_model host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte), .rd_req(rd_req),
      .rd_data(rd_data), .rd_valid(rd_valid));
   //==========================================================
   // clock and shared tasks
   always #2.5 core_clk = ~core_clk;
   // compare and count
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // one conversion result; flags are settled one edge later
   task automatic sample(input logic [10:0] vin, input logic [10:0] vout);
      @(posedge core_clk);
      sample_valid <= 1'b1;
      vin_sample <= vin;
      vout_sample <= vout;
      @(posedge core_clk);
      sample_valid <= 1'b0;
      #1;
   endtask : sample
   // verdict, the only place the run ends
   task automatic summarize();
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // watchdog: the whole sequence needs well under 1000 cycles
   initial begin
      #20000;
      failures++;
      summarize();
   end
   //==========================================================
   // main sequence
   initial begin
      core_clk = 1'b0;
      rst_b = 1'b0;
      fine_res_sel = 1'b0;
      mid_res_sel = 1'b0;
      sample_valid = 1'b0;
      vin_sample = 11'h000;
      vout_sample = 11'h000;
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      // reset value and quiet flags
      host.read_word(IVT_CMD_OV_FAULT, rd, ok);
      check(rd, 16'h007F);
      check({12'h0, ov_f, ov_w, uv_w, pg_ok}, 16'h0000);
      // table rows: write then read back
      foreach (rows[i]) begin
         host.write_word(rows[i].code, rows[i].wdat);
         host.read_word(rows[i].code, rd, ok);
         check(rd, rows[i].rdat);
         check({15'h0, ok}, 16'h0001);
      end
      // limits of 10 steps, junk in the upper bits, in every resolution
      host.write_word(IVT_CMD_OV_FAULT, 16'hFF8A);
      host.write_word(IVT_CMD_OV_WARN, 16'hFF8A);
      host.write_word(IVT_CMD_UV_WARN, 16'hFF8A);
      for (int m = 0; m < 3; m++) begin
         @(posedge core_clk);
         fine_res_sel <= (m == 2);
         mid_res_sel <= (m == 1);
         thr = 11'h00A << (3 - m); // 500, 250, 125 mV in 62.5 mV units
         for (int d = -1; d < 2; d++) begin
            sample(thr + 11'(d), 11'h000);
            check({13'h0, ov_f, ov_w, uv_w}, {13'h0, d > 0, d > 0, d < 0});
         end
      end
      // warning limit below the fault limit: only warnings trip at 15 units
      host.write_word(IVT_CMD_OV_WARN, 16'hFF85);
      sample(11'h00F, 11'h000);
      check({13'h0, ov_f, ov_w, uv_w}, 16'h0003);
      // power-good rise at 20 units, fall at 10
      host.write_word(IVT_CMD_GOOD_RISE, 16'h0014);
      host.write_word(IVT_CMD_GOOD_FALL, 16'h000A);
      foreach (pg_v[i]) begin
         sample(11'h0A0, pg_v[i]);
         check({15'h0, pg_ok}, {15'h0, pg_e[i]});
      end
      // mid-run reset: flags clear and every limit returns to its default
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge core_clk);
      check({12'h0, ov_f, ov_w, uv_w, pg_ok}, 16'h0000);
      rst_b <= 1'b1;
      host.read_word(IVT_CMD_OV_FAULT, rd, ok);
      check(rd, {9'h000, IVT_RST_OV_FAULT});
      host.read_word(IVT_CMD_OV_WARN, rd, ok);
      check(rd, {9'h000, IVT_RST_OV_WARN});
      host.read_word(IVT_CMD_UV_WARN, rd, ok);
      check(rd, {9'h000, IVT_RST_UV_WARN});
      host.read_word(IVT_CMD_GOOD_RISE, rd, ok);
      check(rd, {6'h00, IVT_RST_GOOD_RISE});
      host.read_word(IVT_CMD_GOOD_FALL, rd, ok);
      check(rd, {6'h00, IVT_RST_GOOD_FALL});
      // a lone low byte never commits, and a later word pairs afresh
      host.write_lone(IVT_CMD_OV_WARN, 8'h22);
      host.read_word(IVT_CMD_OV_WARN, rd, ok);
      check(rd, {9'h000, IVT_RST_OV_WARN});
      host.write_word(IVT_CMD_OV_WARN, 16'h0011);
      host.read_word(IVT_CMD_OV_WARN, rd, ok);
      check(rd, 16'h0011);
      summarize();
   end
endmodule : test_input_voltage_threshold_regs
